// *** hdl/cwg_shutdown_deadband_config.sv ***
// Shutdown source enables and rising/falling dead-band generation.
//
// Summary of operation
// RL1: Logic cell two output causes shutdown only while its enable bit 3 is set.
// RL2: Comparator two causes shutdown when bit 2 set; reads zero on small variant.
// RL3: Comparator one causes shutdown only while its enable bit 1 is set.
// RL4: Pin-selected generator input causes shutdown only while bit 0 is set.
// RL5: Nonzero rising count N delays rising-edge output by N system clocks, or N-1 to N fast oscillator periods.
// RL6: Nonzero falling count N delays falling-edge output by N system clocks, or N-1 to N fast oscillator periods.
// RL7: A zero count bypasses dead-band for that edge entirely.
// RL8: Unimplemented upper bits of the three registers read as zero.
// RL9: All enables and counts are read/write and clear to zero on reset.
// RL10: After status clears, outputs stay shut down until next data rising edge.
// RL11: Code 00 drives the pair's inactive level after the dead-band interval.
// RL12: Generator clock is system clock when select is 0, fast oscillator at 1.
// RL13: Any enabled active source raises shutdown and sets the status bit.
`timescale 1ns/10ps
`default_nettype none
module cwg_shutdown_deadband_config
  import cwg_cfg_pkg::*;
#(
  parameter bit HAS_COMPARATOR_TWO = 1'b1
)(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic fast_osc_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic generator_data_in,
  input wire logic pin_selected_generator_input_in,
  input wire logic first_comparator_output_in,
  input wire logic second_comparator_output_in,
  input wire logic second_logic_cell_output_in,
  input wire logic polarity_a_in,
  input wire logic polarity_b_in,
  output logic out_a_out,
  output logic out_b_out,
  output logic oe_a_out,
  output logic oe_b_out,
  output logic shutdown_active_out
);
  // --------------------------------------------------------------------------
  // Reset release and input synchronisers
  // --------------------------------------------------------------------------
  logic rst_s1_ff, rst_s2_ff, rst_b;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_b = rst_s2_ff;

  // Order: fast oscillator, data, pin, comparator one, two, logic cell two.
  logic [5:0] pins_raw, sync1_ff, sync2_ff;
  assign pins_raw = {second_logic_cell_output_in, second_comparator_output_in,
                     first_comparator_output_in,
                     pin_selected_generator_input_in, generator_data_in,
                     fast_osc_in};
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end else if (ce_in) begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [3:0] enables_ff, nxt_enables;
  logic [5:0] rise_cnt_ff, nxt_rise_cnt;
  logic [5:0] fall_cnt_ff, nxt_fall_cnt;
  logic [1:0] pair_ac_shutdown_state_ff, nxt_pair_ac;
  logic [1:0] pair_bd_shutdown_state_ff, nxt_pair_bd;
  logic clk_select_ff, nxt_clk_select;
  logic status_ff, nxt_status;
  logic [7:0] rdata_ff, nxt_rdata;
  logic shut_event;

  always_comb begin
    nxt_enables = enables_ff;
    nxt_rise_cnt = rise_cnt_ff;
    nxt_fall_cnt = fall_cnt_ff;
    nxt_pair_ac = pair_ac_shutdown_state_ff;
    nxt_pair_bd = pair_bd_shutdown_state_ff;
    nxt_clk_select = clk_select_ff;
    nxt_status = status_ff;
    nxt_rdata = 8'h00;
    if (wr_in) begin
      unique case (addr_in)
        ADDR_SHUTDOWN_SOURCE_ENABLES: begin
          nxt_enables = wdata_in[3:0]; // RL9
          if (!HAS_COMPARATOR_TWO) begin
            nxt_enables[COMPARATOR_TWO_BIT] = 1'b0; // RL2
          end
        end
        ADDR_RISING_DEADBAND_COUNT: nxt_rise_cnt = wdata_in[5:0]; // RL9
        ADDR_FALLING_DEADBAND_COUNT: nxt_fall_cnt = wdata_in[5:0]; // RL9
        ADDR_SHUTDOWN_CONTROL: begin
          nxt_status = wdata_in[SHUTDOWN_STATUS_BIT];
          nxt_pair_bd = wdata_in[PAIR_BD_LSB +: 2];
          nxt_pair_ac = wdata_in[PAIR_AC_LSB +: 2];
        end
        ADDR_CLOCK_SELECT: nxt_clk_select = wdata_in[0];
        default: ;
      endcase
    end
    // A live shutdown source beats a software clear in the same cycle.
    if (shut_event) begin
      nxt_status = 1'b1; // RL13
    end
    if (rd_in) begin
      unique case (addr_in)
        ADDR_SHUTDOWN_SOURCE_ENABLES: nxt_rdata = {4'h0, enables_ff}; // RL8
        ADDR_RISING_DEADBAND_COUNT: nxt_rdata = {2'h0, rise_cnt_ff}; // RL8
        ADDR_FALLING_DEADBAND_COUNT: nxt_rdata = {2'h0, fall_cnt_ff}; // RL8
        ADDR_SHUTDOWN_CONTROL: nxt_rdata = {status_ff, 1'b0,
                                            pair_bd_shutdown_state_ff,
                                            pair_ac_shutdown_state_ff, 2'h0};
        ADDR_CLOCK_SELECT: nxt_rdata = {7'h00, clk_select_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      enables_ff <= RST_SOURCE_ENABLES; // RL9
      rise_cnt_ff <= RST_DELAY_COUNT; // RL9
      fall_cnt_ff <= RST_DELAY_COUNT; // RL9
      pair_ac_shutdown_state_ff <= RST_PAIR_STATE;
      pair_bd_shutdown_state_ff <= RST_PAIR_STATE;
      clk_select_ff <= 1'b0;
      status_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else if (ce_in) begin
      enables_ff <= nxt_enables;
      rise_cnt_ff <= nxt_rise_cnt;
      fall_cnt_ff <= nxt_fall_cnt;
      pair_ac_shutdown_state_ff <= nxt_pair_ac;
      pair_bd_shutdown_state_ff <= nxt_pair_bd;
      clk_select_ff <= nxt_clk_select;
      status_ff <= nxt_status;
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata_out = rdata_ff;

  // --------------------------------------------------------------------------
  // Shutdown sources
  // --------------------------------------------------------------------------
  logic src_cell2, src_cmp2, src_cmp1, src_pin;
  assign src_cell2 = enables_ff[LOGIC_CELL_TWO_BIT] & sync2_ff[5]; // RL1
  assign src_cmp2 = enables_ff[COMPARATOR_TWO_BIT] & sync2_ff[4]; // RL2
  assign src_cmp1 = enables_ff[COMPARATOR_ONE_BIT] & sync2_ff[3]; // RL3
  assign src_pin = enables_ff[PIN_INPUT_BIT] & sync2_ff[2]; // RL4
  assign shut_event = src_cell2 | src_cmp2 | src_cmp1 | src_pin; // RL13

  // --------------------------------------------------------------------------
  // Generator clock tick and data edges
  // --------------------------------------------------------------------------
  // The oscillator is sampled, so its period must exceed two system periods.
  logic osc_d_ff, data_d_ff, hold_ff, nxt_hold;
  logic tick, data_rise, data_fall;
  assign tick = clk_select_ff ? (sync2_ff[0] & ~osc_d_ff) : 1'b1; // RL12
  assign data_rise = sync2_ff[1] & ~data_d_ff;
  assign data_fall = ~sync2_ff[1] & data_d_ff;

  always_comb begin
    nxt_hold = hold_ff;
    if (status_ff) begin
      nxt_hold = 1'b1;
    end else if (data_rise) begin
      nxt_hold = 1'b0; // RL10
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      osc_d_ff <= 1'b0;
      data_d_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else if (ce_in) begin
      osc_d_ff <= sync2_ff[0];
      data_d_ff <= sync2_ff[1];
      hold_ff <= nxt_hold;
    end
  end

  // --------------------------------------------------------------------------
  // Dead-band delays
  // --------------------------------------------------------------------------
  logic rise_busy, rise_done, fall_busy, fall_done;
  edge_delay u_rise (
    .clk_in(clk_sys_in),
    .rst_b_in(rst_b),
    .ce_in(ce_in),
    .tick_in(tick),
    .start_in(data_rise),
    .abort_in(data_fall),
    .count_in(rise_cnt_ff), // RL5
    .busy_out(rise_busy),
    .done_out(rise_done)
  );
  edge_delay u_fall (
    .clk_in(clk_sys_in),
    .rst_b_in(rst_b),
    .ce_in(ce_in),
    .tick_in(tick),
    .start_in(data_fall),
    .abort_in(data_rise),
    .count_in(fall_cnt_ff), // RL6
    .busy_out(fall_busy),
    .done_out(fall_done)
  );

  // Output A follows the delayed rising edge, output B the delayed falling.
  logic a_ff, nxt_a, b_ff, nxt_b;
  always_comb begin
    nxt_a = a_ff;
    nxt_b = b_ff;
    if (data_fall) begin
      nxt_a = 1'b0;
    end else if (rise_done) begin
      nxt_a = 1'b1; // RL5
    end
    if (data_rise) begin
      nxt_b = 1'b0;
    end else if (fall_done) begin
      nxt_b = 1'b1; // RL6
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      a_ff <= 1'b0;
      b_ff <= 1'b0;
    end else if (ce_in) begin
      a_ff <= nxt_a;
      b_ff <= nxt_b;
    end
  end

  // --------------------------------------------------------------------------
  // Output stage with shutdown override
  // --------------------------------------------------------------------------
  logic shut;
  logic sync_pol_a_ff, sync_pol_b_ff;
  logic [1:0] oa_ff, nxt_oa, ob_ff, nxt_ob;
  assign shut = status_ff | hold_ff;

  function automatic logic [1:0] pin_value(
    input logic [1:0] code,
    input logic live,
    input logic pol,
    input logic settled
  );
    // Result is {enable, level}.
    logic [1:0] res;
    res = {1'b1, live ^ pol};
    unique case (code)
      // Inactive level waits for the running dead-band to finish.
      STATE_INACTIVE: res = settled ? {1'b1, pol} : {1'b1, live ^ pol};
      STATE_TRISTATE: res = 2'b00;
      STATE_LOW: res = 2'b10;
      STATE_HIGH: res = 2'b11;
    endcase
    return res;
  endfunction : pin_value

  always_comb begin
    nxt_oa = {1'b1, a_ff ^ sync_pol_a_ff};
    nxt_ob = {1'b1, b_ff ^ sync_pol_b_ff};
    if (shut) begin
      nxt_oa = pin_value(pair_ac_shutdown_state_ff, a_ff, sync_pol_a_ff,
                         ~rise_busy); // RL11
      nxt_ob = pin_value(pair_bd_shutdown_state_ff, b_ff, sync_pol_b_ff,
                         ~fall_busy); // RL11
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      oa_ff <= 2'b00;
      ob_ff <= 2'b00;
      sync_pol_a_ff <= 1'b0;
      sync_pol_b_ff <= 1'b0;
    end else if (ce_in) begin
      oa_ff <= nxt_oa;
      ob_ff <= nxt_ob;
      sync_pol_a_ff <= polarity_a_in;
      sync_pol_b_ff <= polarity_b_in;
    end
  end

  assign out_a_out = oa_ff[0];
  assign oe_a_out = oa_ff[1];
  assign out_b_out = ob_ff[0];
  assign oe_b_out = ob_ff[1];
  assign shutdown_active_out = shut;
endmodule : cwg_shutdown_deadband_config
`default_nettype wire

// *** hdl/cwg_cfg_pkg.sv ***
// Constants shared by the dead-band and shutdown configuration block.
package cwg_cfg_pkg;
  // ------------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------------
  localparam logic [3:0] ADDR_SHUTDOWN_SOURCE_ENABLES = 4'h0;
  localparam logic [3:0] ADDR_RISING_DEADBAND_COUNT = 4'h1;
  localparam logic [3:0] ADDR_FALLING_DEADBAND_COUNT = 4'h2;
  localparam logic [3:0] ADDR_SHUTDOWN_CONTROL = 4'h3;
  localparam logic [3:0] ADDR_CLOCK_SELECT = 4'h4;
  // ------------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------------
  localparam int LOGIC_CELL_TWO_BIT = 3;
  localparam int COMPARATOR_TWO_BIT = 2;
  localparam int COMPARATOR_ONE_BIT = 1;
  localparam int PIN_INPUT_BIT = 0;
  localparam int SHUTDOWN_STATUS_BIT = 7;
  localparam int PAIR_BD_LSB = 4;
  localparam int PAIR_AC_LSB = 2;
  localparam int COUNT_W = 6;
  // ------------------------------------------------------------------------
  // Reset values, bypass count and pair shutdown codes
  // ------------------------------------------------------------------------
  localparam logic [3:0] RST_SOURCE_ENABLES = 4'h0;
  localparam logic [5:0] RST_DELAY_COUNT = 6'h00;
  localparam logic [1:0] RST_PAIR_STATE = 2'h0;
  localparam logic [5:0] DELAY_BYPASS = 6'h00;
  localparam logic [1:0] STATE_INACTIVE = 2'h0;
  localparam logic [1:0] STATE_TRISTATE = 2'h1;
  localparam logic [1:0] STATE_LOW = 2'h2;
  localparam logic [1:0] STATE_HIGH = 2'h3;
endpackage : cwg_cfg_pkg

// *** hdl/edge_delay.sv ***
// Dead-band delay for one edge of the generator data waveform.
`timescale 1ns/10ps
`default_nettype none
module edge_delay
  import cwg_cfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic tick_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [COUNT_W-1:0] count_in,
  output logic busy_out,
  output logic done_out
);
  logic [COUNT_W-1:0] cnt_ff, nxt_cnt;
  logic busy_ff, nxt_busy;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    done_out = 1'b0;
    if (abort_in) begin
      nxt_busy = 1'b0;
    end else if (start_in) begin
      // A zero count takes the bypass path and never loads.
      if (count_in == DELAY_BYPASS) begin
        done_out = 1'b1; // RL7
      end else begin
        nxt_busy = 1'b1;
        nxt_cnt = count_in;
      end
    end else if (busy_ff && tick_in) begin
      // The first tick may come at once, so the wait spans N-1 to N periods.
      if (cnt_ff == 6'h01) begin
        nxt_busy = 1'b0;
        done_out = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 6'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff <= RST_DELAY_COUNT;
      busy_ff <= 1'b0;
    end else if (ce_in) begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  assign busy_out = busy_ff;
endmodule : edge_delay
`default_nettype wire

// *** verification/bridge_switch_model.sv ***
// Switch driver load that sits on the two bridge output pins.
`timescale 1ns/10ps
`default_nettype none
module bridge_switch_model (
  input wire logic a_in,
  input wire logic b_in,
  input wire logic oe_a_in,
  input wire logic oe_b_in,
  output logic pin_a_out,
  output logic pin_b_out
);
  // Driver gates carry pull-downs, so a released pin reads low, never held.
  assign pin_a_out = oe_a_in ? a_in : 1'b0;
  assign pin_b_out = oe_b_in ? b_in : 1'b0;
endmodule : bridge_switch_model
`default_nettype wire

// *** verification/cwg_cfg_monitor.sv ***
// Port-level assertions for the dead-band and shutdown block.
`timescale 1ns/10ps
`default_nettype none
module cwg_cfg_monitor
  import cwg_cfg_pkg::*;
#(
  parameter bit HAS_COMPARATOR_TWO = 1'b1
)(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic generator_data_in,
  input wire logic pin_selected_generator_input_in,
  input wire logic first_comparator_output_in,
  input wire logic second_comparator_output_in,
  input wire logic second_logic_cell_output_in,
  input wire logic polarity_a_in,
  input wire logic out_a_out,
  input wire logic shutdown_active_out
);
  logic [3:0] src;
  logic [3:0] en_ff;
  logic [3:0] nxt_en;
  assign src = {second_logic_cell_output_in, second_comparator_output_in,
    first_comparator_output_in, pin_selected_generator_input_in};
  // ------------------------------------------------------------------
  // Shadow of the enables, so causes are judged without looking inside.
  // ------------------------------------------------------------------
  always_comb begin
    nxt_en = en_ff;
    if (wr_in && addr_in == ADDR_SHUTDOWN_SOURCE_ENABLES) begin
      nxt_en = wdata_in[3:0] & {1'b1, HAS_COMPARATOR_TWO, 2'h3};
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_ff <= 4'h0;
    end else begin
      en_ff <= nxt_en;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  property p_src(int b);
    (en_ff[b] && src[b]) [*4] |-> ##1 shutdown_active_out;
  endproperty
  a_cell_two_gate: assert property (p_src(3)) else $error("cell two");
  a_cmp_two_gate: assert property (p_src(2)) else $error("cmp two");
  a_cmp_one_gate: assert property (p_src(1)) else $error("cmp one");
  a_pin_gate: assert property (p_src(0)) else $error("pin source");
  a_shut_cause: assert property ($rose(shutdown_active_out) |->
    |($past(en_ff & src) | $past(en_ff & src, 2) | $past(en_ff & src, 3)) ||
    $past(wr_in && addr_in == ADDR_SHUTDOWN_CONTROL &&
    wdata_in[SHUTDOWN_STATUS_BIT]))
    else $error("shutdown without cause");
  a_enable_readback: assert property (
    rd_in && addr_in == ADDR_SHUTDOWN_SOURCE_ENABLES |=>
    rdata_out == {4'h0, $past(en_ff)}) else $error("enable readback");
  a_hold_until_edge: assert property (
    (!generator_data_in) [*5] ##0 shutdown_active_out |=> shutdown_active_out)
    else $error("shutdown released early");
  a_rise_after_data: assert property (
    $rose(out_a_out) && !shutdown_active_out && !polarity_a_in |->
    $past(generator_data_in, 2)) else $error("output rose without data");
  c_release: cover property (shutdown_active_out ##1 !shutdown_active_out);
  c_out_a_rise: cover property ($rose(out_a_out));
  c_clock_sel: cover property (wr_in && addr_in == ADDR_CLOCK_SELECT);
endmodule : cwg_cfg_monitor
`default_nettype wire

// *** verification/cwg_shutdown_deadband_config_tb.sv ***
// Self-checking testbench for the dead-band and shutdown block.
`timescale 1ns/10ps
`default_nettype none
module cwg_shutdown_deadband_config_tb
  import cwg_cfg_pkg::*;
();
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic fast_osc_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic data_in = 1'b0;
  logic pol_a = 1'b0;
  logic [3:0] src = 4'h0;
  logic [7:0] rdata_out;
  logic out_a_out;
  logic out_b_out;
  logic oe_a_out;
  logic oe_b_out;
  logic shutdown_active_out;
  logic pin_a;
  logic pin_b;
  int fail_count = 0;
  int checks = 0;
  cwg_shutdown_deadband_config DUT (
    .clk_sys_in, .rst_b_in, .ce_in(1'b1), .fast_osc_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .generator_data_in(data_in),
    .pin_selected_generator_input_in(src[0]),
    .first_comparator_output_in(src[1]),
    .second_comparator_output_in(src[2]),
    .second_logic_cell_output_in(src[3]),
    .polarity_a_in(pol_a), .polarity_b_in(1'b0), .out_a_out, .out_b_out,
    .oe_a_out, .oe_b_out, .shutdown_active_out);
  bridge_switch_model drv (.a_in(out_a_out), .b_in(out_b_out),
    .oe_a_in(oe_a_out), .oe_b_in(oe_b_out), .pin_a_out(pin_a),
    .pin_b_out(pin_b));
  // ------------------------------------------------------------------
  // Bus and checking tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(negedge clk_sys_in);
    d = rdata_out;
  endtask : rd
  task automatic do_reset;
    @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    repeat (20) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
  endtask : do_reset
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  task automatic test_regs;
    logic [7:0] d;
    logic [7:0] mask [3] = '{8'h0F, 8'h3F, 8'h3F};
    for (int i = 0; i < 3; i++) begin
      rd(4'(i), d);
      chk(d, 8'h00);
      wr(4'(i), 8'hFF);
      rd(4'(i), d);
      chk(d, mask[i]);
      wr(4'(i), 8'h2A);
      rd(4'(i), d);
      chk(d, 8'h2A & mask[i]);
    end
    wr(4'hF, 8'hFF);
    rd(4'hF, d);
    chk(d, 8'h00);
    do_reset;
    for (int i = 0; i < 3; i++) begin
      rd(4'(i), d);
      chk(d, 8'h00);
    end
    $display("register test done");
  endtask : test_regs
  task automatic edge_time(input logic lvl, output int n);
    @(posedge clk_sys_in);
    data_in <= lvl;
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (((lvl ? out_a_out : out_b_out) !== 1'b1) && n < 200);
    // An edge that never arrives is a failure on its own.
    if (n >= 200) begin
      fail_count++;
    end
  endtask : edge_time
  task automatic test_deadband;
    int t0r;
    int t0f;
    int tr;
    int tf;
    logic [5:0] n [4] = '{6'h00, 6'h01, 6'h02, 6'h3F};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_RISING_DEADBAND_COUNT, {2'h0, n[i]});
      wr(ADDR_FALLING_DEADBAND_COUNT, {2'h0, n[i]});
      edge_time(1'b1, tr);
      edge_time(1'b0, tf);
      if (i == 0) begin
        t0r = tr;
        t0f = tf;
        chk(8'(t0r), 8'(t0f));
        chk(8'(t0r), 8'h05);
      end
      chk(8'(tr - t0r), {2'h0, n[i]});
      chk(8'(tf - t0f), {2'h0, n[i]});
    end
    $display("dead-band test done");
  endtask : test_deadband
  task automatic test_clock;
    logic [7:0] d;
    wr(ADDR_CLOCK_SELECT, 8'h01);
    wr(ADDR_RISING_DEADBAND_COUNT, 8'h02);
    rd(ADDR_CLOCK_SELECT, d);
    chk(d, 8'h01);
    @(posedge clk_sys_in);
    data_in <= 1'b1;
    cyc(20);
    chk({7'h00, out_a_out}, 8'h00);
    repeat (4) begin
      @(posedge clk_sys_in);
      fast_osc_in <= 1'b1;
      cyc(3);
      @(posedge clk_sys_in);
      fast_osc_in <= 1'b0;
      cyc(3);
    end
    chk({7'h00, out_a_out}, 8'h01);
    wr(ADDR_CLOCK_SELECT, 8'h00);
    data_in <= 1'b0;
    cyc(4);
    $display("clock select test done");
  endtask : test_clock
  task automatic test_shutdown;
    logic [1:0] code;
    logic [7:0] d;
    logic [3:0] exp [4] = '{4'hE, 4'h0, 4'hC, 4'hF};
    wr(ADDR_RISING_DEADBAND_COUNT, 8'h00);
    wr(ADDR_FALLING_DEADBAND_COUNT, 8'h00);
    pol_a <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      code = 2'(i);
      wr(ADDR_SHUTDOWN_CONTROL, {2'h0, code, code, 2'h0});
      wr(ADDR_SHUTDOWN_SOURCE_ENABLES, {4'h0, ~(4'h1 << i)});
      src <= 4'h1 << i;
      cyc(8);
      chk({7'h00, shutdown_active_out}, 8'h00);
      wr(ADDR_SHUTDOWN_SOURCE_ENABLES, {4'h0, 4'h1 << i});
      cyc(80);
      chk({7'h00, shutdown_active_out}, 8'h01);
      chk({4'h0, oe_a_out, oe_b_out, pin_a, pin_b}, {4'h0, exp[i]});
      @(posedge clk_sys_in);
      src <= 4'h0;
      cyc(6);
      wr(ADDR_SHUTDOWN_CONTROL, {2'h0, code, code, 2'h0});
      cyc(6);
      chk({7'h00, shutdown_active_out}, 8'h01);
      @(posedge clk_sys_in);
      data_in <= 1'b1;
      cyc(8);
      chk({7'h00, shutdown_active_out}, 8'h00);
      @(posedge clk_sys_in);
      data_in <= 1'b0;
      cyc(4);
    end
    // Software may force the shutdown state by setting the status bit.
    wr(ADDR_SHUTDOWN_CONTROL, 8'h80);
    cyc(2);
    chk({7'h00, shutdown_active_out}, 8'h01);
    rd(ADDR_SHUTDOWN_CONTROL, d);
    chk(d, 8'h80);
    wr(ADDR_SHUTDOWN_CONTROL, 8'h00);
    cyc(6);
    chk({7'h00, shutdown_active_out}, 8'h01);
    @(posedge clk_sys_in);
    data_in <= 1'b1;
    cyc(8);
    chk({7'h00, shutdown_active_out}, 8'h00);
    @(posedge clk_sys_in);
    data_in <= 1'b0;
    cyc(4);
    $display("shutdown test done");
  endtask : test_shutdown
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  // The tests need about 900 cycles; the watchdog allows 15,000, over sixteen times that.
  initial begin
    #300000;
    fail_count++;
    final_report;
  end
  initial begin
    do_reset;
    test_regs;
    test_deadband;
    test_clock;
    test_shutdown;
    final_report;
  end
endmodule : cwg_shutdown_deadband_config_tb
bind cwg_shutdown_deadband_config cwg_cfg_monitor #(
  .HAS_COMPARATOR_TWO(HAS_COMPARATOR_TWO)) u_mon (.clk_sys_in, .rst_b_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .generator_data_in,
  .pin_selected_generator_input_in, .first_comparator_output_in,
  .second_comparator_output_in, .second_logic_cell_output_in,
  .polarity_a_in, .out_a_out, .shutdown_active_out);
`default_nettype wire
